// ---- pio_pkg.sv ----
// Purpose: constants for the port and external bus block
// Assumes: 125 MHz system clock
// Notes: register offsets are byte addresses on AXI4-Lite
package pio_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 8;
  localparam int HS_SETUP_NS = 63;
  localparam int HS_SETUP_CYC = (HS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int MEM_PHASE_NS = 100;
  localparam int MEM_PHASE_CYC = (MEM_PHASE_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_P0_MODE = 8'h00;
  localparam logic [7:0] OFS_P0_DATA = 8'h04;
  localparam logic [7:0] OFS_P1_MODE = 8'h08;
  localparam logic [7:0] OFS_P1_DATA = 8'h0c;
  localparam logic [7:0] OFS_P2_DIR = 8'h10;
  localparam logic [7:0] OFS_P2_DATA = 8'h14;
  localparam logic [7:0] OFS_P2_CFG = 8'h18;
  localparam logic [7:0] OFS_P3_MODE = 8'h1c;
  localparam logic [7:0] OFS_P3_DATA = 8'h20;
  localparam logic [7:0] OFS_IRQ_EDGE = 8'h24;
  localparam logic [7:0] OFS_TMR_ROUTE = 8'h28;
  localparam logic [7:0] OFS_MEM_CMD = 8'h2c;
  localparam logic [7:0] OFS_MEM_WDATA = 8'h30;
  localparam logic [7:0] OFS_MEM_STAT = 8'h34;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int P0M_ADDR_LO = 0;
  localparam int P0M_ADDR_HI = 1;
  localparam int P0M_OUT_LO = 2;
  localparam int P0M_OUT_HI = 3;
  localparam int P0M_PU_LO = 4;
  localparam int P0M_PU_HI = 5;
  localparam int P0M_HS = 6;
  localparam int P1M_GPO = 0;
  localparam int P1M_FLOAT = 1;
  localparam int P2C_PP = 0;
  localparam int P2C_PU = 1;
  localparam int P2C_HS = 2;
  localparam int P3M_ANALOG = 1;
  localparam int P3M_DM = 2;
  localparam int IRQ_EDGE_LSB = 6;
  localparam int TMRA_T8 = 0;
  localparam int TMRB_SEL_LSB = 12;
  localparam int TMRB_EDGE_P20 = 9;
  localparam int TMRC_T16 = 16;
  localparam int CMD_WRITE = 16;
  localparam int CMD_DM = 17;
  localparam int STAT_BUSY = 8;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001, HS_SETUP = 5'b00010, HS_WAIT_LO = 5'b00100,
    HS_WAIT_HI = 5'b01000, HS_IN_FULL = 5'b10000
  } pio_hs_state_t;
  typedef enum logic [4:0] {
    MC_IDLE = 5'b00001, MC_ADDR = 5'b00010, MC_HOLD = 5'b00100,
    MC_DATA = 5'b01000, MC_END = 5'b10000
  } pio_mc_state_t;
endpackage

// ---- pio_top.sv ----
// Purpose: four I/O ports, external memory bus and byte handshakes
// Assumes: all pin inputs synchronous to clk_sys
// Notes: two-way pins are split into in, out and output enable
module pio_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port 0
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  output logic [7:0] port0_pullup,
  // Port 1
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  // Port 2
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe,
  output logic [7:0] port2_pullup,
  // Port 3 pins and comparator results
  input wire logic pin3_bit1,
  input wire logic pin3_bit2,
  input wire logic pin3_bit3,
  input wire logic cmp_a_hi,
  input wire logic cmp_b_hi,
  output logic pin3_bit4,
  output logic pin3_bit5,
  output logic pin3_bit6,
  output logic pin3_bit7,
  // Bus strobes
  output logic address_strobe_n,
  output logic address_strobe_oe,
  output logic data_strobe_n,
  output logic data_strobe_oe,
  output logic read_write_n,
  output logic read_write_oe,
  // Program memory select
  input wire logic internal_rom_disable,
  output logic fetch_external,
  // Timer taps and events
  input wire logic timer8_out,
  input wire logic timer16_out,
  input wire logic and_or_out,
  output logic timer_edge_src,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic ext_irq_c,
  output logic stop_recovery_src,
  output logic wake_or,
  output logic wake_and
);
  import pio_pkg::*;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rd_mux;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic rd_ok;

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFS_MEM_STAT;
  endfunction

  function automatic logic [7:0] upd8(input logic [7:0] old, input logic [7:0] d, input logic s);
    return s ? d : old;
  endfunction

  // Handshake outputs straight from holding flags
  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready = ~w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  wire rd_fire = s_axi_arvalid & ~rvalid_r;
  wire [7:0] wa = awaddr_r;
  wire [7:0] wd = wdata_r[7:0];
  wire wr_p0m = wr_fire & (wa == OFS_P0_MODE);
  wire wr_p0d = wr_fire & (wa == OFS_P0_DATA);
  wire wr_p1m = wr_fire & (wa == OFS_P1_MODE);
  wire wr_p1d = wr_fire & (wa == OFS_P1_DATA);
  wire wr_p2r = wr_fire & (wa == OFS_P2_DIR);
  wire wr_p2d = wr_fire & (wa == OFS_P2_DATA);
  wire wr_p2c = wr_fire & (wa == OFS_P2_CFG);
  wire wr_p3m = wr_fire & (wa == OFS_P3_MODE);
  wire wr_p3d = wr_fire & (wa == OFS_P3_DATA);
  wire wr_irq = wr_fire & (wa == OFS_IRQ_EDGE);
  wire wr_tmr = wr_fire & (wa == OFS_TMR_ROUTE);
  wire wr_cmd = wr_fire & (wa == OFS_MEM_CMD);
  wire wr_mwd = wr_fire & (wa == OFS_MEM_WDATA);
  wire rd_p0d = rd_fire & (s_axi_araddr == OFS_P0_DATA);
  wire rd_p2d = rd_fire & (s_axi_araddr == OFS_P2_DATA);

  // Address and data are held separately so either may come first
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response and read data
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [7:0] p0_mode_r, p0_data_r, p1_mode_r, p1_data_r, p2_dir_r, p2_data_r;
  logic [7:0] p2_cfg_r, p3_mode_r, p3_data_r, irq_edge_r, mem_wdata_r;
  logic [23:0] tmr_route_r;
  logic [17:0] mem_cmd_r;
  logic mem_busy;

  // Only lane 0 matters for byte registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      p0_mode_r <= REG8_RST;
      p0_data_r <= REG8_RST;
      p1_mode_r <= REG8_RST;
      p1_data_r <= REG8_RST;
      p2_dir_r <= REG8_RST;
      p2_data_r <= REG8_RST;
      p2_cfg_r <= REG8_RST;
      p3_mode_r <= REG8_RST;
      p3_data_r <= REG8_RST;
      irq_edge_r <= REG8_RST;
      mem_wdata_r <= REG8_RST;
    end else begin
      if (wr_p0m) p0_mode_r <= upd8(p0_mode_r, wd, wstrb_r[0]);
      if (wr_p0d) p0_data_r <= upd8(p0_data_r, wd, wstrb_r[0]);
      if (wr_p1m) p1_mode_r <= upd8(p1_mode_r, wd, wstrb_r[0]);
      if (wr_p1d) p1_data_r <= upd8(p1_data_r, wd, wstrb_r[0]);
      if (wr_p2r) p2_dir_r <= upd8(p2_dir_r, wd, wstrb_r[0]);
      if (wr_p2d) p2_data_r <= upd8(p2_data_r, wd, wstrb_r[0]);
      if (wr_p2c) p2_cfg_r <= upd8(p2_cfg_r, wd, wstrb_r[0]);
      if (wr_p3m) p3_mode_r <= upd8(p3_mode_r, wd, wstrb_r[0]);
      if (wr_p3d) p3_data_r <= upd8(p3_data_r, wd, wstrb_r[0]);
      if (wr_irq) irq_edge_r <= upd8(irq_edge_r, wd, wstrb_r[0]);
      if (wr_mwd) mem_wdata_r <= upd8(mem_wdata_r, wd, wstrb_r[0]);
    end
  end

  // Wide registers; a command is dropped while a cycle runs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tmr_route_r <= 24'h00_0000;
      mem_cmd_r <= 18'h0_0000;
    end else begin
      if (wr_tmr) tmr_route_r <= wdata_r[23:0];
      if (wr_cmd && !mem_busy) mem_cmd_r <= wdata_r[17:0];
    end
  end

  // ----------------------------------------
  // Byte handshakes on ports 0 and 2
  // ----------------------------------------
  logic [1:0] hs_en, hs_dir_out, hs_in_line, hs_go, hs_ack, hs_out_line, hs_busy;
  logic [7:0] hs_pins [2];
  logic [7:0] hs_latch [2];
  assign hs_en = {p2_cfg_r[P2C_HS], p0_mode_r[P0M_HS]};
  assign hs_dir_out = {p2_dir_r[7], p0_mode_r[P0M_OUT_HI]};
  assign hs_in_line = {pin3_bit1, pin3_bit2};
  assign hs_go = {wr_p2d, wr_p0d};
  assign hs_ack = {rd_p2d, rd_p0d};
  assign hs_pins[0] = port0_in;
  assign hs_pins[1] = port2_in;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_hs
      pio_hs_state_t st_r;
      logic [3:0] cnt_r;
      logic read_r;
      logic [7:0] lat_r;
      // Ready returns only after the byte is read and valid is gone
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          st_r <= HS_IDLE;
          cnt_r <= 4'h0;
          read_r <= 1'b0;
          lat_r <= 8'h00;
        end else if (!hs_en[c]) begin
          st_r <= HS_IDLE;
          read_r <= 1'b0;
        end else begin
          unique case (st_r)
            HS_IDLE: begin
              cnt_r <= 4'h0;
              read_r <= 1'b0;
              if (hs_dir_out[c] && hs_go[c]) begin
                st_r <= HS_SETUP;
              end else if (!hs_dir_out[c] && !hs_in_line[c]) begin
                lat_r <= hs_pins[c];
                st_r <= HS_IN_FULL;
              end
            end
            HS_SETUP: begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'(HS_SETUP_CYC - 1)) st_r <= HS_WAIT_LO;
            end
            HS_WAIT_LO: if (!hs_in_line[c]) st_r <= HS_WAIT_HI;
            HS_WAIT_HI: if (hs_in_line[c]) st_r <= HS_IDLE;
            HS_IN_FULL: begin
              if (hs_ack[c]) read_r <= 1'b1;
              if ((read_r || hs_ack[c]) && hs_in_line[c]) st_r <= HS_IDLE;
            end
          endcase
        end
      end
      // Valid low only while waiting; ready high only when empty
      assign hs_out_line[c] = !hs_en[c] ? 1'b1 :
        hs_dir_out[c] ? (st_r != HS_WAIT_LO) : (st_r == HS_IDLE);
      assign hs_busy[c] = st_r != HS_IDLE;
      assign hs_latch[c] = lat_r;
    end
  endgenerate

  // ----------------------------------------
  // External memory machine cycle
  // ----------------------------------------
  pio_mc_state_t mc_r;
  logic [3:0] ph_r;
  logic [7:0] mem_rdata_r;
  logic mc_start;
  assign mem_busy = mc_r != MC_IDLE;
  assign mc_start = wr_cmd & wstrb_r[2] & ~mem_busy;
  wire ph_tick = ph_r == 4'(MEM_PHASE_CYC - 1);
  wire wr_cyc = mem_cmd_r[CMD_WRITE];

  // Phase divider: one enable pulse per bus phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ph_r <= 4'h0;
    end else if (!mem_busy || ph_tick) begin
      ph_r <= 4'h0;
    end else begin
      ph_r <= ph_r + 4'h1;
    end
  end

  // Address, hold, data, recovery; read data caught as the strobe rises
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mc_r <= MC_IDLE;
      mem_rdata_r <= 8'h00;
    end else begin
      unique case (mc_r)
        MC_IDLE: if (mc_start) mc_r <= MC_ADDR;
        MC_ADDR: if (ph_tick) mc_r <= MC_HOLD;
        MC_HOLD: if (ph_tick) mc_r <= MC_DATA;
        MC_DATA: begin
          if (ph_tick) begin
            mc_r <= MC_END;
            if (!wr_cyc) mem_rdata_r <= port1_in;
          end
        end
        MC_END: if (ph_tick) mc_r <= MC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire bus_float = p1_mode_r[P1M_FLOAT];
  wire addr_lo = p0_mode_r[P0M_ADDR_LO];
  wire addr_hi = p0_mode_r[P0M_ADDR_HI];
  wire addr_ph = (mc_r == MC_ADDR) | (mc_r == MC_HOLD);
  wire [15:0] mem_addr = mem_cmd_r[15:0];

  // Strobes and read/write float together under software control
  assign address_strobe_n = ~(mc_r == MC_ADDR);
  assign data_strobe_n = ~(mc_r == MC_DATA);
  assign read_write_n = ~(mem_busy & wr_cyc);
  assign address_strobe_oe = ~bus_float;
  assign data_strobe_oe = ~bus_float;
  assign read_write_oe = ~bus_float;

  // Port 0 nibbles: address bits or plain I/O
  assign port0_out[3:0] = addr_lo ? mem_addr[11:8] : p0_data_r[3:0];
  assign port0_out[7:4] = addr_hi ? mem_addr[15:12] : p0_data_r[7:4];
  assign port0_oe[3:0] = {4{addr_lo ? ~bus_float : p0_mode_r[P0M_OUT_LO]}};
  assign port0_oe[7:4] = {4{addr_hi ? ~bus_float : p0_mode_r[P0M_OUT_HI]}};
  assign port0_pullup = {{4{p0_mode_r[P0M_PU_HI]}}, {4{p0_mode_r[P0M_PU_LO]}}} & ~port0_oe;

  // Port 1: multiplexed address/data or plain output
  wire p1_gpo = p1_mode_r[P1M_GPO];
  assign port1_out = p1_gpo ? p1_data_r : (addr_ph ? mem_addr[7:0] : mem_wdata_r);
  assign port1_oe = {8{p1_gpo | (~bus_float & mem_busy & (addr_ph | wr_cyc))}};

  // Port 2: open-drain drives only a low
  assign port2_out = p2_data_r;
  assign port2_oe = p2_dir_r & ({8{p2_cfg_r[P2C_PP]}} | ~p2_data_r);
  assign port2_pullup = {8{p2_cfg_r[P2C_PU]}} & ~p2_dir_r;

  // Port 3 outputs: data select, handshakes, timer taps
  wire [1:0] tmr_sel = tmr_route_r[TMRB_SEL_LSB +: 2];
  logic p3_b6_src;
  always_comb begin
    unique case (tmr_sel)
      2'h1: p3_b6_src = timer8_out;
      2'h2: p3_b6_src = timer16_out;
      2'h3: p3_b6_src = and_or_out;
      default: p3_b6_src = p3_data_r[6];
    endcase
  end
  wire dm_n = ~(mem_busy & mem_cmd_r[CMD_DM]);
  assign pin3_bit4 = p3_mode_r[P3M_DM] ? dm_n : (tmr_route_r[TMRA_T8] ? timer8_out : p3_data_r[4]);
  assign pin3_bit5 = hs_en[0] ? hs_out_line[0] : (tmr_route_r[TMRC_T16] ? timer16_out : p3_data_r[5]);
  assign pin3_bit6 = hs_en[1] ? hs_out_line[1] : p3_b6_src;
  assign pin3_bit7 = p3_data_r[7];

  // ----------------------------------------
  // Port 3 inputs, comparators and edge events
  // ----------------------------------------
  wire analog = p3_mode_r[P3M_ANALOG];
  wire line1 = analog ? cmp_a_hi : pin3_bit1;
  wire line2 = analog ? cmp_b_hi : pin3_bit2;
  wire line3 = analog ? 1'b0 : pin3_bit3;
  wire [1:0] edge_sel = irq_edge_r[IRQ_EDGE_LSB +: 2];
  logic l1_r, l2_r, l3_r, irq_a_r, irq_b_r, irq_c_r, fetch_r, stop_r;

  function automatic logic hit(input logic prev, input logic now, input logic [1:0] s);
    return s == EDGE_FALL ? (prev & ~now) : s == EDGE_RISE ? (~prev & now) : (prev ^ now);
  endfunction

  // Inputs are synchronous, so one stage is enough for edges
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      l1_r <= 1'b1;
      l2_r <= 1'b1;
      l3_r <= 1'b1;
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
      irq_c_r <= 1'b0;
      fetch_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      l1_r <= line1;
      l2_r <= line2;
      l3_r <= line3;
      irq_a_r <= hit(l2_r, line2, edge_sel);
      irq_c_r <= hit(l1_r, line1, edge_sel);
      irq_b_r <= ~analog & l3_r & ~line3;
      stop_r <= analog & pin3_bit3;
      fetch_r <= ~internal_rom_disable;
    end
  end
  assign ext_irq_a = irq_a_r;
  assign ext_irq_b = irq_b_r;
  assign ext_irq_c = irq_c_r;
  assign stop_recovery_src = stop_r;
  assign fetch_external = fetch_r;

  // Port 2 wake gates and timer edge source
  assign wake_or = |port2_in;
  assign wake_and = &port2_in;
  assign timer_edge_src = tmr_route_r[TMRB_EDGE_P20] ? port2_in[0] : line1;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] p3_in = {4'h0, line3, line2, line1, 1'b0};
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFS_P0_MODE: rd_mux = {24'h0, p0_mode_r};
      OFS_P0_DATA: rd_mux = {24'h0, hs_en[0] & ~hs_dir_out[0] ? hs_latch[0] : port0_in};
      OFS_P1_MODE: rd_mux = {24'h0, p1_mode_r};
      OFS_P1_DATA: rd_mux = {24'h0, port1_in};
      OFS_P2_DIR: rd_mux = {24'h0, p2_dir_r};
      OFS_P2_DATA: rd_mux = {24'h0, hs_en[1] & ~hs_dir_out[1] ? hs_latch[1] : port2_in};
      OFS_P2_CFG: rd_mux = {24'h0, p2_cfg_r};
      OFS_P3_MODE: rd_mux = {24'h0, p3_mode_r};
      OFS_P3_DATA: rd_mux = {24'h0, p3_data_r[7:4], p3_in[3:0]};
      OFS_IRQ_EDGE: rd_mux = {24'h0, irq_edge_r};
      OFS_TMR_ROUTE: rd_mux = {8'h0, tmr_route_r};
      OFS_MEM_CMD: rd_mux = {14'h0, mem_cmd_r};
      OFS_MEM_WDATA: rd_mux = {24'h0, mem_wdata_r};
      OFS_MEM_STAT: rd_mux = {20'h0, fetch_r, hs_busy, mem_busy, mem_rdata_r};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
endmodule // pio_top

// ---- pio_top_asserts.sv ----
// Purpose: concurrent checks on the port and bus block
// Assumes: one clock domain, reset active high
// Notes: attached by the bind after the module
module pio_top_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Strobes
  input wire logic address_strobe_n,
  input wire logic address_strobe_oe,
  input wire logic data_strobe_n,
  input wire logic data_strobe_oe,
  input wire logic read_write_n,
  input wire logic read_write_oe,
  // Ports and fetch select
  input wire logic [7:0] port0_oe,
  input wire logic [7:0] port0_pullup,
  input wire logic [7:0] port1_oe,
  input wire logic internal_rom_disable,
  input wire logic fetch_external
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Strobe shapes, 13 clocks a phase
  chk_ds_width: assert property ($fell(data_strobe_n) |-> !data_strobe_n[*8] ##6 data_strobe_n)
    else $error("data strobe width");
  chk_as_width: assert property ($fell(address_strobe_n) |-> ##13 $rose(address_strobe_n))
    else $error("address strobe width");
  chk_as_to_ds: assert property ($rose(address_strobe_n) |-> ##13 $fell(data_strobe_n))
    else $error("data strobe late");
  // Direction line and float against the bus drivers; pull-ups and fetch select
  chk_rw_write: assert property (!read_write_n && !data_strobe_n |-> port1_oe == 8'hff)
    else $error("write data not driven");
  chk_rw_fall: assert property ($fell(read_write_n) |-> ##[0:2] $fell(address_strobe_n))
    else $error("write outside a cycle");
  chk_float_all: assert property (!address_strobe_oe |-> !data_strobe_oe && !read_write_oe && port1_oe == 8'h00)
    else $error("bus not fully floated");
  chk_pullup_off: assert property ((port0_pullup & port0_oe) == 8'h00)
    else $error("pull-up on output");
  chk_rom_select: assert property ($stable(internal_rom_disable)[*2] |-> fetch_external != internal_rom_disable)
    else $error("fetch select wrong");
  cov_write: cover property ($fell(data_strobe_n) && !read_write_n);
  cov_read: cover property ($fell(data_strobe_n) && read_write_n);
  cov_float: cover property (!address_strobe_oe);
endmodule // pio_top_asserts
bind pio_top pio_top_asserts u_chk (.*);

// ---- pio_mem_model.sv ----
// Purpose: byte memory on the multiplexed bus
// Assumes: address then data on port 1
// Notes: released bus toggles every clock
module pio_mem_model (
  // Clock
  input wire logic clk_sys,
  // Bus from the block
  input wire logic [7:0] port1_out,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write_n,
  // Read data
  output logic [7:0] mem_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] addr_r;
  logic as_r, ds_r;
  initial mem_drive = 8'h5a;
  // Latch at strobe trailing edges, drive memory data inside the data strobe and a toggling value outside it
  always @(posedge clk_sys) begin
    as_r <= address_strobe_n;
    ds_r <= data_strobe_n;
    if (address_strobe_n && !as_r) addr_r <= port1_out;
    if (data_strobe_n && !ds_r && !read_write_n) mem[addr_r] <= port1_out;
    mem_drive <= data_strobe_n ? ~mem_drive : mem[addr_r];
  end
endmodule // pio_mem_model

// ---- pio_top_tb.sv ----
// Purpose: self-checking bench for the port and bus block
// Assumes: 125 MHz clock, memory model on port 1
// Notes: shadow registers and memory data predicted here
module pio_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  logic clk_sys, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pin3_bit1, pin3_bit2, pin3_bit3, cmp_a_hi;
  logic cmp_b_hi, pin3_bit4, pin3_bit5, pin3_bit6, pin3_bit7, address_strobe_n, address_strobe_oe, wake_or;
  logic data_strobe_n, data_strobe_oe, read_write_n, read_write_oe, internal_rom_disable, fetch_external;
  logic timer8_out, timer16_out, and_or_out, timer_edge_src, ext_irq_a, ext_irq_b, ext_irq_c, wake_and;
  logic stop_recovery_src;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port0_in, port0_out, port0_oe, port0_pullup, port1_in, port1_out;
  logic [7:0] port1_oe, port2_in, port2_out, port2_oe, port2_pullup, mem_drive, d, lo;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int errors, check_count, ds_count, sh[int];
  pio_top dut (.*);
  pio_mem_model mem (.*);
  // Pin levels from all drivers
  assign port1_in = (port1_oe & port1_out) | (~port1_oe & mem_drive);
  assign port0_in = port0_oe & port0_out;
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(negedge data_strobe_n) ds_count++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang;
    errors++;
    $display("[FAIL] %0t timeout", $time);
    give_verdict();
  endtask
  // Selector 0 irq a, 1 port 2 handshake line, 2 irq b
  task automatic wait_for(input int w, input logic v);
    int n;
    logic s;
    n = 0;
    s = w == 2 ? ext_irq_b : w == 1 ? pin3_bit6 : ext_irq_a;
    while (s !== v && n < 2000) begin
      @(posedge clk_sys);
      n++;
      s = w == 2 ? ext_irq_b : w == 1 ? pin3_bit6 : ext_irq_a;
    end
    if (s !== v) hang();
  endtask
  // Bus tasks hold each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    sh[a] = v & 32'hff;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 99);
    s_axi_bready <= 0;
    if (n == 99) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 99);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    if (n == 99) hang();
  endtask
  task automatic mem_op(input logic [31:0] c);
    int n;
    n = 0;
    wr(OFS_MEM_CMD, c);
    do begin
      rd(OFS_MEM_STAT);
      n++;
    end while (rv[STAT_BUSY] !== 1'b0 && n < 99);
    if (n == 99) hang();
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, port2_in} = '0;
    s_axi_wstrb = 4'hf;
    {pin3_bit1, pin3_bit2, pin3_bit3, internal_rom_disable} = 4'hf;
    {cmp_a_hi, cmp_b_hi, timer8_out, timer16_out, and_or_out} = '0;
    reset = 1;
    void'($urandom(17));
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    chk(port0_oe, 0);
    chk(port2_oe, 0);
    rd(OFS_P2_CFG);
    chk(rv, 0);
    rd(8'h3c);
    chk(rr, RESP_SLVERR);
    d = 8'($urandom);
    lo = 8'($urandom);
    port2_in <= lo;
    wr(OFS_P2_DIR, 32'hff);
    wr(OFS_P2_DATA, d);
    chk(port2_oe, d ^ 8'hff);
    chk({wake_or, wake_and}, {|lo, &lo});
    wr(OFS_P2_CFG, 1);
    chk(port2_oe, 8'hff);
    chk(port2_out, d);
    rd(OFS_P2_DIR);
    chk(rv, sh[OFS_P2_DIR]);
    wr(OFS_P0_MODE, 32'h34);
    chk({port0_oe, port0_pullup}, 16'h0ff0);
    wr(OFS_P0_MODE, 3);
    wr(OFS_MEM_WDATA, d);
    mem_op({16'h1, 8'h12, lo});
    chk({port0_oe, port0_out}, 16'hff12);
    mem_op({16'h0, 8'h12, lo});
    chk(rv[7:0], d);
    chk(ds_count, 2);
    wr(OFS_P1_MODE, 2);
    chk({address_strobe_oe, data_strobe_oe, read_write_oe, port1_oe}, 0);
    wr(OFS_P1_MODE, 1);
    wr(OFS_P1_DATA, lo);
    chk({port1_oe, port1_out}, {8'hff, lo});
    internal_rom_disable <= 0;
    repeat (2) @(posedge clk_sys);
    chk(fetch_external, 1);
    wr(OFS_P3_DATA, 32'h80);
    wr(OFS_TMR_ROUTE, 32'h1_1001);
    {timer8_out, timer16_out} <= 2'b11;
    @(posedge clk_sys);
    chk({pin3_bit4, pin3_bit5, pin3_bit6, pin3_bit7}, 4'hf);
    wr(OFS_P3_MODE, 2);
    @(posedge clk_sys);
    chk(stop_recovery_src, 1);
    rd(OFS_P3_DATA);
    chk(rv[7:0], 8'h80);
    wr(OFS_P3_MODE, 0);
    pin3_bit3 <= 0;
    wait_for(2, 1);
    wr(OFS_IRQ_EDGE, 32'h40);
    pin3_bit2 <= 0;
    @(posedge clk_sys);
    pin3_bit2 <= 1;
    wait_for(0, 1);
    wr(OFS_P2_CFG, 5);
    wr(OFS_P2_DATA, lo);
    wait_for(1, 0);
    chk(port2_out, lo);
    pin3_bit1 <= 0;
    wait_for(1, 1);
    pin3_bit1 <= 1;
    give_verdict();
  end
endmodule // pio_top_tb
